/* include/tcm_defines.svh */
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH

// ==========================================
// control token values
`define TCM_TOK_END 8'h01
`define TCM_TOK_ACK 8'h03
`define TCM_TOK_NAK 8'h04
`define TCM_TOK_WR 8'hC0
`define TCM_TOK_RD 8'hC1

// ==========================================
// field sizes in bytes less one, and codes
`define TCM_NOREPLY 8'hFF
`define TCM_RID_BYTES 2'h2
`define TCM_NUM_BYTES 2'h1
`define TCM_DAT_BYTES 2'h3
`define TCM_NREG 16'h0008
`define TCM_REG_RST 32'h00000000
`define TCM_PS_TYPE 24'h00000B
`define TCM_PS_SHIFT 8

// ==========================================
// symbol indices of a reply
`define TCM_RSP_LAST_RD 3'h5
`define TCM_RSP_LAST 3'h1

// ==========================================
// symbol indices of a request and of the reply it gets
`define TCM_REQ_LAST_WR 4'hA
`define TCM_REQ_LAST_RD 4'h6
`define TCM_RX_RD_END 3'h5
`define TCM_RX_WR_END 3'h1

`endif

/* include/tcm_pkg.sv */
package tcm_pkg;
`include "tcm_defines.svh"

   // one link symbol: control flag plus byte
   typedef struct packed {
      logic ctl;
      logic [7:0] dat;
   } tcm_sym_s;

   typedef enum logic [2:0] {
      D_HDR = 3'b000,
      D_RID = 3'b001,
      D_NUM = 3'b010,
      D_DAT = 3'b011,
      D_END = 3'b100,
      D_ERR = 3'b101,
      D_TX = 3'b110
   } tcm_dst_e;

   typedef enum logic [1:0] {
      Q_IDLE = 2'b00,
      Q_TX = 2'b01,
      Q_RX = 2'b10
   } tcm_qst_e;

   typedef logic [7:0][31:0] tcm_regs_t;
endpackage

/* include/tcm_if.sv */
`timescale 1ns/1ps
interface tcm_if;
   logic req_valid;
   logic req_ready;
   tcm_pkg::tcm_sym_s req_sym;
   logic rsp_valid;
   logic rsp_ready;
   tcm_pkg::tcm_sym_s rsp_sym;
   logic [23:0] rsp_dest;

   modport dev (
      input req_valid,
      input req_sym,
      input rsp_ready,
      output req_ready,
      output rsp_valid,
      output rsp_sym,
      output rsp_dest
   );

   modport host (
      output req_valid,
      output req_sym,
      output rsp_ready,
      input req_ready,
      input rsp_valid,
      input rsp_sym,
      input rsp_dest
   );
endinterface

/* core/tcm_req.sv */
`timescale 1ns/1ps
module tcm_req (
   input wire logic clk_sys,
   input wire logic rst_b,
   tcm_if.host lnk,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_write,
   input wire logic [23:0] cmd_rid,
   input wire logic [15:0] cmd_reg,
   input wire logic [31:0] cmd_wdata,
   output logic res_valid,
   output logic res_ok,
   output logic [31:0] res_rdata
);
   import tcm_pkg::*;

   typedef struct packed {
      tcm_qst_e st;
      logic wr;
      logic [23:0] rid;
      logic [15:0] num;
      logic [31:0] dat;
      logic [3:0] idx;
      logic o_vld;
      tcm_sym_s o_sym;
      logic in_rdy;
      logic [2:0] rcnt;
      logic rok;
      logic cmd_rdy;
      logic res_vld;
      logic res_ok;
      logic [31:0] res_dat;
   } tcm_req_s;

   localparam tcm_req_s REQ_RST = '{st: Q_IDLE, cmd_rdy: 1'b1, default: '0};

   tcm_req_s s_r;
   tcm_req_s s_nxt;

   // ==========================================
   // request symbol by index, msb first
   function automatic tcm_sym_s req_sym(input logic [3:0] i, input logic w,
                                        input logic [23:0] r, input logic [15:0] n,
                                        input logic [31:0] d);
      tcm_sym_s y;
      y = '{ctl: 1'b0, dat: 8'h00};
      case (i)
         4'h0: y = '{ctl: 1'b1, dat: w ? `TCM_TOK_WR : `TCM_TOK_RD};
         4'h1: y.dat = r[23:16];
         4'h2: y.dat = r[15:8];
         4'h3: y.dat = r[7:0];
         4'h4: y.dat = n[15:8];
         4'h5: y.dat = n[7:0];
         4'h6: y = w ? '{ctl: 1'b0, dat: d[31:24]} : '{ctl: 1'b1, dat: `TCM_TOK_END};
         4'h7: y.dat = d[23:16];
         4'h8: y.dat = d[15:8];
         4'h9: y.dat = d[7:0];
         default: y = '{ctl: 1'b1, dat: `TCM_TOK_END};
      endcase
      return y;
   endfunction

   // ==========================================
   // next state
   always_comb begin
      s_nxt = s_r;
      s_nxt.res_vld = 1'b0;
      case (s_r.st)
         Q_IDLE: begin
            if (cmd_valid && s_r.cmd_rdy) begin
               s_nxt.wr = cmd_write;
               s_nxt.rid = cmd_rid;
               s_nxt.num = cmd_reg;
               s_nxt.dat = cmd_wdata;
               s_nxt.idx = 4'h0;
               s_nxt.o_vld = 1'b1;
               s_nxt.o_sym = req_sym(4'h0, cmd_write, cmd_rid, cmd_reg, cmd_wdata);
               s_nxt.cmd_rdy = 1'b0;
               s_nxt.st = Q_TX;
            end
         end
         Q_TX: begin
            if (s_r.o_vld && lnk.req_ready) begin
               if (s_r.idx == (s_r.wr ? `TCM_REQ_LAST_WR : `TCM_REQ_LAST_RD)) begin
                  s_nxt.o_vld = 1'b0;
                  if (s_r.wr && s_r.rid[7:0] == `TCM_NOREPLY) begin
                     s_nxt.res_vld = 1'b1;
                     s_nxt.res_ok = 1'b1;
                     s_nxt.cmd_rdy = 1'b1;
                     s_nxt.st = Q_IDLE;
                  end else begin
                     s_nxt.in_rdy = 1'b1;
                     s_nxt.rcnt = 3'h0;
                     s_nxt.st = Q_RX;
                  end
               end else begin
                  s_nxt.idx = s_r.idx + 4'h1;
                  s_nxt.o_sym = req_sym(s_nxt.idx, s_r.wr, s_r.rid, s_r.num, s_r.dat);
               end
            end
         end
         Q_RX: begin
            if (lnk.rsp_valid && s_r.in_rdy) begin
               if (s_r.rcnt == 3'h0) begin
                  s_nxt.rok = lnk.rsp_sym.ctl && lnk.rsp_sym.dat == `TCM_TOK_ACK;
                  s_nxt.rcnt = 3'h1;
               end else if (lnk.rsp_sym.ctl) begin
                  s_nxt.res_vld = 1'b1;
                  s_nxt.res_ok = s_r.rok && lnk.rsp_sym.dat == `TCM_TOK_END &&
                                 s_r.rcnt == (s_r.wr ? `TCM_RX_WR_END : `TCM_RX_RD_END);
                  s_nxt.in_rdy = 1'b0;
                  s_nxt.cmd_rdy = 1'b1;
                  s_nxt.st = Q_IDLE;
               end else begin
                  s_nxt.res_dat = {s_r.res_dat[23:0], lnk.rsp_sym.dat};
                  s_nxt.rcnt = s_r.rcnt + 3'h1;
               end
            end
         end
         default: s_nxt = REQ_RST;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= REQ_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lnk.req_valid = s_r.o_vld;
   assign lnk.req_sym = s_r.o_sym;
   assign lnk.rsp_ready = s_r.in_rdy;
   assign cmd_ready = s_r.cmd_rdy;
   assign res_valid = s_r.res_vld;
   assign res_ok = s_r.res_ok;
   assign res_rdata = s_r.res_dat;
endmodule

/* core/tcm_dev.sv */
`timescale 1ns/1ps
module tcm_dev (
   input wire logic clk_sys,
   input wire logic rst_b,
   tcm_if.dev lnk,
   input wire logic [15:0] ps_num,
   input wire logic ps_wr,
   input wire logic [31:0] ps_wdata,
   output logic [31:0] ps_rdata,
   output logic [23:0] ps_resid
);
   import tcm_pkg::*;

   typedef struct packed {
      tcm_dst_e st;
      logic wr;
      logic has_id;
      logic [1:0] cnt;
      logic [23:0] rid;
      logic [15:0] num;
      logic [31:0] dat;
      logic [2:0] tx_idx;
      logic tx_ok;
      tcm_regs_t regs;
      logic in_rdy;
      logic o_vld;
      tcm_sym_s o_sym;
      logic k_vld;
      tcm_sym_s k_sym;
      logic [23:0] dest;
      logic [31:0] ps_rdata;
      logic [23:0] ps_resid;
   } tcm_dev_s;

   localparam tcm_dev_s DEV_RST = '{st: D_HDR, in_rdy: 1'b1, default: '0};

   tcm_dev_s s_r;
   tcm_dev_s s_nxt;

   logic acc;
   logic pop;
   logic push;
   logic num_ok;
   tcm_sym_s sym;

   // ==========================================
   // helpers
   function automatic logic reg_hit(input logic [15:0] n);
      return n < `TCM_NREG;
   endfunction

   // write whose reply id ends in all ones
   function automatic logic no_reply(input logic w, input logic [23:0] r);
      return w && r[7:0] == `TCM_NOREPLY;
   endfunction

   function automatic logic [23:0] ps_id(input logic [15:0] n);
      return ({8'h00, n} << `TCM_PS_SHIFT) | `TCM_PS_TYPE;
   endfunction

   function automatic tcm_sym_s rsp_sym(input logic [2:0] i, input logic ok,
                                        input logic w, input logic [31:0] d);
      tcm_sym_s y;
      y = '{ctl: 1'b1, dat: `TCM_TOK_END};
      if (i == 3'h0) begin
         y.dat = ok ? `TCM_TOK_ACK : `TCM_TOK_NAK;
      end else if (ok && !w) begin
         case (i)
            3'h1: y = '{ctl: 1'b0, dat: d[31:24]};
            3'h2: y = '{ctl: 1'b0, dat: d[23:16]};
            3'h3: y = '{ctl: 1'b0, dat: d[15:8]};
            3'h4: y = '{ctl: 1'b0, dat: d[7:0]};
            default: y = '{ctl: 1'b1, dat: `TCM_TOK_END};
         endcase
      end
      return y;
   endfunction

   // ==========================================
   // next state
   always_comb begin
      s_nxt = s_r;
      acc = lnk.req_valid && s_r.in_rdy;
      pop = s_r.o_vld && lnk.rsp_ready;
      sym = lnk.req_sym;
      num_ok = reg_hit(s_r.num);
      push = 1'b0;

      // status port, one word per access
      // full word access
      if (ps_wr && reg_hit(ps_num)) begin
         s_nxt.regs[ps_num[2:0]] = ps_wdata;
      end
      s_nxt.ps_rdata = reg_hit(ps_num) ? s_r.regs[ps_num[2:0]] : `TCM_REG_RST;
      s_nxt.ps_resid = ps_id(ps_num);

      // reply buffer drain
      if (pop) begin
         s_nxt.o_vld = s_r.k_vld;
         s_nxt.o_sym = s_r.k_sym;
         s_nxt.k_vld = 1'b0;
      end

      case (s_r.st)
         D_HDR: begin
            if (acc) begin
               if (sym.ctl && (sym.dat == `TCM_TOK_WR || sym.dat == `TCM_TOK_RD)) begin
                  s_nxt.wr = sym.dat == `TCM_TOK_WR;
                  s_nxt.has_id = 1'b0;
                  s_nxt.cnt = `TCM_RID_BYTES;
                  s_nxt.st = D_RID;
               end else if (!(sym.ctl && sym.dat == `TCM_TOK_END)) begin
                  s_nxt.has_id = 1'b0;
                  s_nxt.st = D_ERR;
               end
            end
         end
         D_RID, D_NUM, D_DAT: begin
            if (acc) begin
               if (sym.ctl) begin
                  s_nxt.st = (sym.dat == `TCM_TOK_END && s_r.has_id) ? D_TX : D_ERR;
                  if (sym.dat == `TCM_TOK_END && (!s_r.has_id || no_reply(s_r.wr, s_r.rid))) begin
                     s_nxt.st = D_HDR;
                  end
                  s_nxt.tx_ok = 1'b0;
                  s_nxt.tx_idx = 3'h0;
                  s_nxt.dest = s_r.rid;
               end else begin
                  s_nxt.cnt = s_r.cnt - 2'h1;
                  case (s_r.st)
                     D_RID: s_nxt.rid = {s_r.rid[15:0], sym.dat};
                     D_NUM: s_nxt.num = {s_r.num[7:0], sym.dat};
                     default: s_nxt.dat = {s_r.dat[23:0], sym.dat};
                  endcase
                  if (s_r.cnt == 2'h0) begin
                     case (s_r.st)
                        D_RID: begin
                           s_nxt.has_id = 1'b1;
                           s_nxt.cnt = `TCM_NUM_BYTES;
                           s_nxt.st = D_NUM;
                        end
                        D_NUM: begin
                           s_nxt.cnt = `TCM_DAT_BYTES;
                           s_nxt.st = s_r.wr ? D_DAT : D_END;
                        end
                        default: s_nxt.st = D_END;
                     endcase
                  end
               end
            end
         end
         D_END: begin
            if (acc) begin
               if (sym.ctl && sym.dat == `TCM_TOK_END) begin
                  s_nxt.tx_ok = num_ok;
                  s_nxt.tx_idx = 3'h0;
                  s_nxt.dest = s_r.rid;
                  s_nxt.st = D_TX;
                  if (s_r.wr && num_ok) begin
                     s_nxt.regs[s_r.num[2:0]] = s_r.dat;
                  end
                  if (!s_r.wr) begin
                     s_nxt.dat = num_ok ? s_r.regs[s_r.num[2:0]] : `TCM_REG_RST;
                  end
                  if (no_reply(s_r.wr, s_r.rid)) begin
                     s_nxt.st = D_HDR;
                  end
               end else begin
                  s_nxt.st = D_ERR;
               end
            end
         end
         D_ERR: begin
            // swallow to the closing token, then fail
            if (acc && sym.ctl && sym.dat == `TCM_TOK_END) begin
               s_nxt.tx_ok = 1'b0;
               s_nxt.tx_idx = 3'h0;
               s_nxt.dest = s_r.rid;
               s_nxt.st = (s_r.has_id && !no_reply(s_r.wr, s_r.rid)) ? D_TX : D_HDR;
            end
         end
         D_TX: begin
            // emit reply while buffer has room
            push = !s_r.k_vld;
            if (push) begin
               s_nxt.tx_idx = s_r.tx_idx + 3'h1;
               if (s_r.tx_idx == ((s_r.tx_ok && !s_r.wr) ? `TCM_RSP_LAST_RD : `TCM_RSP_LAST)) begin
                  s_nxt.st = D_HDR;
               end
            end
         end
         default: s_nxt = DEV_RST;
      endcase

      // reply buffer fill
      if (push) begin
         if (!s_nxt.o_vld) begin
            s_nxt.o_vld = 1'b1;
            s_nxt.o_sym = rsp_sym(s_r.tx_idx, s_r.tx_ok, s_r.wr, s_r.dat);
         end else begin
            s_nxt.k_vld = 1'b1;
            s_nxt.k_sym = rsp_sym(s_r.tx_idx, s_r.tx_ok, s_r.wr, s_r.dat);
         end
      end

      s_nxt.in_rdy = s_nxt.st != D_TX;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_r <= DEV_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign lnk.req_ready = s_r.in_rdy;
   assign lnk.rsp_valid = s_r.o_vld;
   assign lnk.rsp_sym = s_r.o_sym;
   assign lnk.rsp_dest = s_r.dest;
   assign ps_rdata = s_r.ps_rdata;
   assign ps_resid = s_r.ps_resid;
endmodule

/* sim/tcm_monitor.sv */
`timescale 1ns/1ps
`include "tcm_defines.svh"
module tcm_monitor (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire tcm_pkg::tcm_sym_s req_sym,
   input wire logic rsp_valid,
   input wire logic rsp_ready,
   input wire tcm_pkg::tcm_sym_s rsp_sym,
   input wire logic [23:0] rsp_dest
);
   import tcm_pkg::*;
   localparam logic [8:0] t_end = {1'b1, `TCM_TOK_END};
   localparam logic [8:0] t_ack = {1'b1, `TCM_TOK_ACK};
   localparam logic [8:0] t_nak = {1'b1, `TCM_TOK_NAK};
   logic tq, tr, rd_r, hd_r, ok_r;
   logic [3:0] pc_r;
   logic [2:0] nb_r;
   logic [23:0] rid_r;
   assign tq = req_valid && req_ready;
   assign tr = rsp_valid && rsp_ready;
   // ==========================================
   // message tracking
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pc_r <= 4'h0;
         rd_r <= 1'b0;
         hd_r <= 1'b1;
         ok_r <= 1'b0;
         nb_r <= 3'h0;
         rid_r <= 24'h000000;
      end else begin
         if (tq) begin
            pc_r <= (req_sym == t_end) ? 4'h0 : pc_r + 4'h1;
            if (pc_r == 4'h0)
               rd_r <= req_sym.dat == `TCM_TOK_RD;
            if (pc_r != 4'h0 && pc_r < 4'h4)
               rid_r <= {rid_r[15:0], req_sym.dat};
         end
         if (tr) begin
            hd_r <= rsp_sym == t_end;
            nb_r <= rsp_sym.ctl ? 3'h0 : nb_r + 3'h1;
            if (hd_r)
               ok_r <= rsp_sym == t_ack;
         end
      end
   end
   // ==========================================
   // assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_b);
   chk_req_hold: assert property (req_valid && !req_ready |=>
      req_valid && $stable(req_sym))
      else $error("request symbol not held");
   chk_req_head: assert property (tq && pc_r == 4'h0 |->
      req_sym == {1'b1, `TCM_TOK_WR} || req_sym == {1'b1, `TCM_TOK_RD})
      else $error("bad request header");
   chk_req_len: assert property (tq && req_sym == t_end |->
      pc_r == (rd_r ? `TCM_REQ_LAST_RD : `TCM_REQ_LAST_WR))
      else $error("bad request length");
   chk_rsp_gap: assert property (tq && req_sym == t_end |=> !rsp_valid)
      else $error("reply too early");
   chk_no_reply: assert property (tq && req_sym == t_end && !rd_r &&
      rid_r[7:0] == `TCM_NOREPLY |=> !rsp_valid [*8])
      else $error("reply to silent write");
   chk_rsp_head: assert property (rsp_valid && hd_r |->
      rsp_sym == t_ack || rsp_sym == t_nak)
      else $error("bad reply head");
   chk_rsp_tail: assert property (tr && !hd_r && rsp_sym.ctl |->
      rsp_sym == t_end && nb_r == (ok_r && rd_r ? 3'h4 : 3'h0))
      else $error("bad reply body");
   chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=>
      rsp_valid && $stable(rsp_sym))
      else $error("reply symbol not held");
   chk_dest_echo: assert property (rsp_valid |-> rsp_dest == rid_r)
      else $error("reply destination wrong");
   cov_read_ok: cover property (tr && rsp_sym == t_end && ok_r && rd_r);
   cov_fail: cover property (tr && rsp_sym == t_nak);
   cov_silent: cover property (tq && req_sym == t_end && !rd_r && rid_r[7:0] == `TCM_NOREPLY);
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "tcm_defines.svh"
module tb_top;
   import tcm_pkg::*;
   localparam logic [7:0] t_end = `TCM_TOK_END;
   localparam logic [7:0] t_ack = `TCM_TOK_ACK;
   localparam logic [7:0] t_nak = `TCM_TOK_NAK;
   localparam logic [7:0] t_wr = `TCM_TOK_WR;
   localparam logic [7:0] t_rd = `TCM_TOK_RD;
   logic clk_sys, rst_b, cv, cw, crdy, rv, rok, pwr;
   logic [23:0] crid, prid;
   logic [15:0] creg, pn;
   logic [31:0] cwd, rrd, pw, prd;
   int fails, cmp_count, k;
   tcm_sym_s rq[$], rs[$], r2[$], ex[$];
   tcm_if lnk();
   tcm_if l2();
   tcm_req i_tcm_req (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk), .cmd_valid(cv),
      .cmd_ready(crdy), .cmd_write(cw), .cmd_rid(crid), .cmd_reg(creg), .cmd_wdata(cwd),
      .res_valid(rv), .res_ok(rok), .res_rdata(rrd));
   tcm_dev i_tcm_dev (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(lnk), .ps_num(pn),
      .ps_wr(pwr), .ps_wdata(pw), .ps_rdata(prd), .ps_resid(prid));
   tcm_dev i_tcm_dev_2 (.clk_sys(clk_sys), .rst_b(rst_b), .lnk(l2), .ps_num(16'h0000),
      .ps_wr(1'b0), .ps_wdata(32'h0), .ps_rdata(), .ps_resid());
   tcm_monitor i_tcm_monitor (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(lnk.req_valid),
      .req_ready(lnk.req_ready), .req_sym(lnk.req_sym), .rsp_valid(lnk.rsp_valid),
      .rsp_ready(lnk.rsp_ready), .rsp_sym(lnk.rsp_sym), .rsp_dest(lnk.rsp_dest));
   // ==========================================
   // clock and link capture
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      if (rst_b && lnk.req_valid && lnk.req_ready)
         rq.push_back(lnk.req_sym);
      if (rst_b && lnk.rsp_valid && lnk.rsp_ready)
         rs.push_back(lnk.rsp_sym);
      if (rst_b && l2.rsp_valid && l2.rsp_ready)
         r2.push_back(l2.rsp_sym);
   end
   // ==========================================
   // tasks
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task lim;
      if (k >= 200) begin
         fails++;
         $display("wrong value handshake expected done seen timeout");
         end_of_test;
      end
   endtask
   task automatic hs(ref logic s);
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
      end while (!s && k < 200);
      #1;
      lim;
   endtask
   task tk(input logic c, input logic [7:0] v);
      ex.push_back({c, v});
   endtask
   task automatic eq(ref tcm_sym_s q[$], input string nm);
      chk({nm, " count"}, q.size(), ex.size());
      foreach (ex[i])
         chk(nm, q[i], ex[i]);
      q.delete();
      ex.delete();
   endtask
   task automatic run(input logic w, input logic [23:0] rid, input logic [15:0] rg,
         input logic [31:0] d, input logic eok, input logic [31:0] erd);
      cw = w;
      crid = rid;
      creg = rg;
      cwd = d;
      cv = 1'b1;
      hs(crdy);
      cv = 1'b0;
      hs(rv);
      chk("result ok", rok, eok);
      if (!w && eok)
         chk("read data", rrd, erd);
      tk(1'b1, w ? t_wr : t_rd);
      for (int i = 2; i >= 0; i--)
         tk(1'b0, rid[8*i+:8]);
      tk(1'b0, rg[15:8]);
      tk(1'b0, rg[7:0]);
      for (int i = 3; i >= 0 && w; i--)
         tk(1'b0, d[8*i+:8]);
      tk(1'b1, t_end);
      eq(rq, "request");
      if (!w || rid[7:0] != `TCM_NOREPLY)
         tk(1'b1, eok ? t_ack : t_nak);
      for (int i = 3; i >= 0 && !w && eok; i--)
         tk(1'b0, erd[8*i+:8]);
      if (!w || rid[7:0] != `TCM_NOREPLY)
         tk(1'b1, t_end);
      eq(rs, "reply");
   endtask
   task s2(input logic c, input logic [7:0] v);
      l2.req_valid = 1'b1;
      l2.req_sym = {c, v};
      hs(l2.req_ready);
   endtask
   task msg2(input logic [7:0] h, input int nb, input logic bad);
      @(posedge clk_sys);
      #1;
      s2(1'b1, h);
      repeat (nb)
         s2(1'b0, 8'h00);
      if (bad)
         s2(1'b0, 8'h55);
      s2(1'b1, t_end);
      l2.req_valid = 1'b0;
      l2.req_sym = ~l2.req_sym;
   endtask
   task wt(input int n);
      k = 0;
      while (r2.size() < n && k < 200) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
      lim;
   endtask
   // ==========================================
   // main sequence
   initial begin
      {cv, cw, pwr, crid, creg, cwd, pn, pw} = '0;
      l2.req_valid = 1'b0;
      l2.req_sym = '0;
      l2.rsp_ready = 1'b1;
      rst_b = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      rst_b = 1'b1;
      run(1'b1, 24'h123456, 16'h0002, 32'hA1B2C3D4, 1'b1, 32'h0);
      run(1'b0, 24'h123456, 16'h0002, 32'h0, 1'b1, 32'hA1B2C3D4);
      run(1'b1, 24'h00AB12, 16'h0100, 32'h1, 1'b0, 32'h0);
      run(1'b0, 24'h00AB12, 16'h0008, 32'h0, 1'b0, 32'h0);
      run(1'b1, 24'h0007FF, 16'h0005, 32'h5555AAAA, 1'b1, 32'h0);
      run(1'b0, 24'h0007FF, 16'h0005, 32'h0, 1'b1, 32'h5555AAAA);
      run(1'b1, 24'h00FFFE, 16'h0007, 32'hFFFFFFFF, 1'b1, 32'h0);
      for (int i = 0; i < 2; i++) begin
         pn = i ? 16'h1234 : 16'h0005;
         @(posedge clk_sys);
         #1;
         chk("status id", prid, ({8'h00, pn} << 8) | 24'h00000B);
         chk("status word", prd, i ? 32'h0 : 32'h5555AAAA);
      end
      pn = 16'h0003;
      pw = 32'hDEADBEEF;
      pwr = 1'b1;
      @(posedge clk_sys);
      #1;
      pwr = 1'b0;
      run(1'b0, 24'h000102, 16'h0003, 32'h0, 1'b1, 32'hDEADBEEF);
      msg2(8'h07, 1, 1'b0);
      msg2(t_wr, 1, 1'b0);
      msg2(t_wr, 3, 1'b0);
      msg2(t_rd, 5, 1'b1);
      wt(4);
      l2.rsp_ready = 1'b0;
      msg2(t_rd, 5, 1'b0);
      repeat (20) @(posedge clk_sys);
      #1;
      chk("stalled count", r2.size(), 4);
      chk("stalled head", l2.rsp_sym, {1'b1, t_ack});
      chk("stalled busy", l2.req_ready, 1'b0);
      l2.rsp_ready = 1'b1;
      wt(10);
      for (int i = 0; i < 2; i++) begin
         tk(1'b1, t_nak);
         tk(1'b1, t_end);
      end
      tk(1'b1, t_ack);
      repeat (4)
         tk(1'b0, 8'h00);
      tk(1'b1, t_end);
      eq(r2, "second link");
      end_of_test;
   end
endmodule
